/* File: include/ncoacc_pkg.sv */
// Shared constants and types for the oscillator clock control and accumulator.
// Assumes one 250 MHz clock and an 8-bit register port.
package ncoacc_pkg;
	localparam int NCOACC_ACC_W = 20;
	localparam logic [2:0] NCOACC_OFS_CLKCON = 3'h0;
	localparam logic [2:0] NCOACC_OFS_ACCL = 3'h1;
	localparam logic [2:0] NCOACC_OFS_ACCH = 3'h2;
	localparam logic [2:0] NCOACC_OFS_ACCU = 3'h3;
	localparam logic [2:0] NCOACC_OFS_INCL = 3'h4;
	localparam logic [2:0] NCOACC_OFS_INCH = 3'h5;
	localparam logic [2:0] NCOACC_OFS_INCU = 3'h6;
	localparam logic [2:0] NCOACC_OFS_CTRL = 3'h7;
	localparam int NCOACC_PWS_LSB = 5;
	localparam int NCOACC_CKS_LSB = 0;
	localparam int NCOACC_EN_BIT = 7;
	localparam int NCOACC_OUT_BIT = 5;
	localparam int NCOACC_POL_BIT = 4;
	localparam int NCOACC_PFM_BIT = 0;
	localparam logic [7:0] NCOACC_RST_BYTE = 8'h00;
	localparam logic [19:0] NCOACC_RST_ACC = 20'h00000;
	localparam logic [1:0] NCOACC_CKS_HFINT = 2'h0;
	localparam logic [1:0] NCOACC_CKS_SYS = 2'h1;
	localparam logic [1:0] NCOACC_CKS_CELL = 2'h2;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ncoacc_req_t;
	typedef struct packed {
		logic [1:0] pdiv;
		logic srcs;
	} ncoacc_src_t;
endpackage

/* File: verilog/ncoacc_pulse.sv */
// Output stage: fixed duty toggle or pulse of 2**n input clock periods.
// Assumes tick is a one-cycle enable at each selected input clock edge.
`timescale 1ns/1ps
module ncoacc_pulse
	import ncoacc_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic tick,
	input wire logic ovf,
	input wire logic enable,
	input wire logic pfm,
	input wire logic [2:0] pws,
	output logic level
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic next_level;
	logic [7:0] width;

	always_comb begin
		width = 8'h01 << pws;
		next_cnt = cnt;
		next_level = level;
		if (!enable) begin
			next_cnt = 8'h00;
			next_level = 1'b0;
		end else if (tick) begin
			// RULE12: pulse or toggle
			if (!pfm) begin
				// RULE3: width ignored here
				if (ovf) begin
					next_level = ~level;
				end
			end else if (ovf) begin
				next_level = 1'b1;
				next_cnt = 8'h01;
			end else if (level) begin
				// RULE1: 2**n periods active
				if (cnt >= width) begin
					next_level = 1'b0;
					next_cnt = 8'h00;
				end else begin
					next_cnt = cnt + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			cnt <= 8'h00;
			level <= 1'b0;
		end else begin
			cnt <= next_cnt;
			level <= next_level;
		end
	end
endmodule

/* File: verilog/ncoacc_top.sv */
// Clock control, 20-bit phase accumulator and increment of the oscillator.
// Assumes the clock sources arrive as single-cycle tick enables on MCLK.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: pulse width code n gives 2**n periods
// RULE2: two-bit field selects input clock
// RULE3: pulse width used only in pulse mode
// RULE4: software keeps width below overflow period
// RULE5: accumulator split into low, high, nibble
// RULE6: upper accumulator bits 7:4 read zero
// RULE7: accumulator runs freely, reads not coherent
// RULE8: no shadow latch for accumulator reads
// RULE9: software writes accumulator only when stopped
// RULE10: increment is upper:high:low concatenation
// RULE11: shadow loads at edge after low write
// RULE12: mode bit picks pulse or toggle output
// RULE13: add increment per edge, carry overflows
// RULE14: writable fields reset to zero
module ncoacc_top
	import ncoacc_pkg::*;
#(
	parameter int ACC_W = NCOACC_ACC_W
)(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic HFINT_TICK,
	input wire logic SYS_TICK,
	input wire logic CELL_TICK,
	output logic [7:0] RDATA,
	output logic NCO_OUT
);
	ncoacc_req_t req;
	logic [7:0] clkcon;
	logic [7:0] ctrl;
	logic [7:0] incl;
	logic [7:0] inch;
	logic [7:0] incu;
	logic [7:0] next_clkcon;
	logic [7:0] next_ctrl;
	logic [7:0] next_incl;
	logic [7:0] next_inch;
	logic [7:0] next_incu;
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;
	logic [ACC_W-1:0] shadow;
	logic [ACC_W-1:0] next_shadow;
	logic [ACC_W-1:0] inc_word;
	logic [ACC_W:0] sum;
	logic ld_pend;
	logic next_ld_pend;
	logic tick;
	logic ovf;
	logic level;
	logic out_q;
	logic next_out_q;
	logic [7:0] next_rdata;
	logic enable;
	logic pfm;
	logic pol;
	logic [2:0] pws;
	logic [1:0] cks;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign enable = ctrl[NCOACC_EN_BIT];
	assign pfm = ctrl[NCOACC_PFM_BIT];
	assign pol = ctrl[NCOACC_POL_BIT];
	assign pws = clkcon[NCOACC_PWS_LSB +: 3];
	assign cks = clkcon[NCOACC_CKS_LSB +: 2];
	// RULE10: upper high low
	assign inc_word = ACC_W'({incu[3:0], inch, incl});

	// RULE2: source select
	always_comb begin
		case (cks)
			NCOACC_CKS_HFINT: tick = HFINT_TICK;
			NCOACC_CKS_SYS: tick = SYS_TICK;
			NCOACC_CKS_CELL: tick = CELL_TICK;
			default: tick = 1'b0;
		endcase
	end

	// RULE13: add with carry
	assign sum = {1'b0, acc} + {1'b0, shadow};
	assign ovf = enable && tick && sum[ACC_W];

	// Configuration bytes written by software
	always_comb begin
		next_clkcon = clkcon;
		next_ctrl = ctrl;
		next_incl = incl;
		next_inch = inch;
		next_incu = incu;
		if (req.wr) begin
			case (req.addr)
				NCOACC_OFS_CLKCON: next_clkcon = req.wdata & 8'hE3;
				NCOACC_OFS_INCL: next_incl = req.wdata;
				NCOACC_OFS_INCH: next_inch = req.wdata;
				NCOACC_OFS_INCU: next_incu = req.wdata & 8'h0F;
				NCOACC_OFS_CTRL: next_ctrl = req.wdata & 8'h91;
				default: ;
			endcase
		end
	end

	// Accumulator, increment shadow and its load request
	always_comb begin
		next_acc = acc;
		next_shadow = shadow;
		next_ld_pend = ld_pend;
		// RULE13: accumulate while enabled
		if (enable && tick) begin
			next_acc = sum[ACC_W-1:0];
		end
		// RULE11: shadow load on edge
		if (ld_pend && tick) begin
			next_shadow = inc_word;
			next_ld_pend = 1'b0;
		end
		if (req.wr) begin
			case (req.addr)
				// RULE9: writes while running unguarded
				NCOACC_OFS_ACCL: next_acc[7:0] = req.wdata;
				NCOACC_OFS_ACCH: next_acc[15:8] = req.wdata;
				NCOACC_OFS_ACCU: next_acc[19:16] = req.wdata[3:0];
				// RULE11: low byte arms load
				NCOACC_OFS_INCL: next_ld_pend = 1'b1;
				default: ;
			endcase
		end
	end

	// RULE12: polarity after the level
	always_comb begin
		next_out_q = level ^ pol;
	end

	// RULE7: live bytes, no latch
	// RULE8: no read shadow
	always_comb begin
		next_rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				NCOACC_OFS_CLKCON: next_rdata = clkcon;
				// RULE5: byte split
				NCOACC_OFS_ACCL: next_rdata = acc[7:0];
				NCOACC_OFS_ACCH: next_rdata = acc[15:8];
				// RULE6: upper nibble zero
				NCOACC_OFS_ACCU: next_rdata = {4'h0, acc[19:16]};
				NCOACC_OFS_INCL: next_rdata = incl;
				NCOACC_OFS_INCH: next_rdata = inch;
				NCOACC_OFS_INCU: next_rdata = incu;
				NCOACC_OFS_CTRL: begin
					next_rdata = ctrl;
					next_rdata[NCOACC_OUT_BIT] = out_q;
				end
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// RULE14: reset to zero
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			clkcon <= NCOACC_RST_BYTE;
			ctrl <= NCOACC_RST_BYTE;
			incl <= NCOACC_RST_BYTE;
			inch <= NCOACC_RST_BYTE;
			incu <= NCOACC_RST_BYTE;
		end else begin
			clkcon <= next_clkcon;
			ctrl <= next_ctrl;
			incl <= next_incl;
			inch <= next_inch;
			incu <= next_incu;
		end
	end

	// RULE14: accumulator clears
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			acc <= NCOACC_RST_ACC;
			shadow <= NCOACC_RST_ACC;
			ld_pend <= 1'b0;
		end else begin
			acc <= next_acc;
			shadow <= next_shadow;
			ld_pend <= next_ld_pend;
		end
	end

	// Output pin and its status copy
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			out_q <= 1'b0;
			NCO_OUT <= 1'b0;
		end else begin
			out_q <= next_out_q;
			NCO_OUT <= next_out_q;
		end
	end

	// Read data stands one cycle
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= next_rdata;
		end
	end

	// RULE12: output stage
	ncoacc_pulse u_pulse (
		.MCLK(MCLK),
		.RESET(RESET),
		.tick(tick),
		.ovf(ovf),
		.enable(enable),
		.pfm(pfm),
		.pws(pws),
		.level(level)
	);
endmodule

/* File: tb/ncoacc_top_monitor.sv */
// Port checks for the oscillator accumulator.
// Assumes the register map of ncoacc_pkg.
`timescale 1ns/1ps
module ncoacc_top_monitor
	import ncoacc_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic HFINT_TICK,
	input wire logic SYS_TICK,
	input wire logic CELL_TICK,
	input wire logic [7:0] RDATA,
	input wire logic NCO_OUT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("idle data");
	a_nibble_zero: assert property (RD && ADDR == 3'h3 |=> !RDATA[7:4])
		else $error("acc nibble");
	a_clkcon_gap: assert property (RD && ADDR == 3'h0 |=> !RDATA[4:2])
		else $error("clkcon gap");
	a_incu_gap: assert property (RD && ADDR == 3'h6 |=> !RDATA[7:4])
		else $error("inc nibble");
	a_clkcon_back: assert property (WR && ADDR == 3'h0 ##1 RD && ADDR == 3'h0
		|=> RDATA == ($past(WDATA, 2) & 8'hE3)) else $error("clkcon");
	a_inch_back: assert property (WR && ADDR == 3'h5 ##1 RD && ADDR == 3'h5
		|=> RDATA == $past(WDATA, 2)) else $error("inch");
	a_rise_cause: assert property ($rose(NCO_OUT) |-> $past(WR) ||
		$past(HFINT_TICK | SYS_TICK | CELL_TICK | WR, 2)) else $error("rise");
	a_reset_quiet: assert property (@(posedge MCLK) disable iff (1'b0)
		$past(RESET) |-> !NCO_OUT && !RDATA) else $error("reset");
endmodule
bind ncoacc_top ncoacc_top_monitor u_mon (.MCLK(MCLK), .RESET(RESET),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .HFINT_TICK(HFINT_TICK),
	.SYS_TICK(SYS_TICK), .CELL_TICK(CELL_TICK), .RDATA(RDATA),
	.NCO_OUT(NCO_OUT));

/* File: tb/ncoacc_top_tb.sv */
// Bench for the oscillator clock control and accumulator.
// Drives the register port and the tick inputs itself.
`timescale 1ns/1ps
module ncoacc_top_tb;
	import ncoacc_pkg::*;
	logic MCLK, RESET, WR, RD, rd_q, NCO_OUT;
	logic [2:0] ADDR, TK, j;
	logic [7:0] WDATA, RDATA;
	logic [7:0] exp_q[$];
	int error_cnt, check_count, seed, n, k;
	ncoacc_top uut (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .HFINT_TICK(TK[0]),
		.SYS_TICK(TK[1]), .CELL_TICK(TK[2]), .RDATA(RDATA),
		.NCO_OUT(NCO_OUT));
	initial begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end
	task automatic chk(input logic [7:0] s, w);
		check_count++;
		if (s !== w) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, s, w);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Op 1 writes, 2 reads expecting d, 0 idles
	task automatic bus(input int op, input logic [2:0] a, input logic [7:0] d);
		WR <= op == 1;
		RD <= op == 2;
		ADDR <= a;
		WDATA <= d;
		if (op == 2)
			exp_q.push_back(d);
		@(posedge MCLK);
	endtask
	always @(posedge MCLK) begin
		if (rd_q)
			chk(RDATA, exp_q.pop_front());
		rd_q <= RD;
	end
	initial begin
		seed = 32'h4521;
		{WR, RD, TK, ADDR, WDATA} = '0;
		RESET = 1'b1;
		repeat (4) @(posedge MCLK);
		RESET <= 1'b0;
		for (k = 0; k < 8; k++)
			bus(2, k[2:0], 8'h00);
		$display("reset done");
		for (k = 0; k < 9; k++) begin
			n = $random(seed);
			j = 3'(1 + k % 3);
			bus(1, 3'h0, n[7:0]);
			bus(2, 3'h0, n[7:0] & 8'hE3);
			bus(1, 3'h5, n[15:8]);
			bus(2, 3'h5, n[15:8]);
			bus(1, j, n[23:16]);
			bus(2, j, n[23:16] & (j == 3'h3 ? 8'h0F : 8'hFF));
		end
		$display("readback done");
		bus(1, 3'h6, 8'h00);
		bus(1, 3'h5, 8'h00);
		bus(1, 3'h4, 8'h01);
		bus(1, 3'h0, 8'h01);
		bus(1, 3'h1, 8'hFE);
		bus(1, 3'h2, 8'hFF);
		bus(1, 3'h3, 8'h0F);
		bus(1, 3'h7, 8'h80);
		bus(0, 3'h0, 8'h00);
		for (k = 0; k < 9; k++) begin
			TK <= 3'h1 << (k % 3);
			@(posedge MCLK);
			TK <= 3'h0;
			@(posedge MCLK);
		end
		chk({7'h0, NCO_OUT}, 8'h01);
		bus(1, 3'h7, 8'h00);
		for (k = 1; k < 4; k++)
			bus(2, k[2:0], 8'h00);
		$display("toggle done");
		// pulse of 2**n ticks, far below overflow
		for (k = 1; k < 4; k++) begin
			bus(1, 3'h0, {k[2:0], 5'h01});
			bus(1, 3'h1, 8'hFF);
			bus(1, 3'h2, 8'hFF);
			bus(1, 3'h3, 8'h0F);
			bus(1, 3'h7, 8'h81);
			bus(0, 3'h0, 8'h00);
			n = 0;
			TK <= 3'h2;
			repeat (24) begin
				@(posedge MCLK);
				n += NCO_OUT;
			end
			TK <= 3'h0;
			chk(n[7:0], 8'h01 << k);
			bus(1, 3'h7, 8'h00);
		end
		bus(0, 3'h0, 8'h00);
		$display("pulse done");
		for (k = 0; k < 4; k++) begin
			bus(1, 3'h0, k[7:0]);
			bus(1, 3'h1, 8'hFF);
			bus(1, 3'h2, 8'hFF);
			bus(1, 3'h3, 8'h0F);
			bus(1, 3'h7, 8'h90);
			bus(0, 3'h0, 8'h00);
			TK <= 3'h7 ^ (3'h1 << k);
			bus(2, 3'h7, 8'hB0);
			TK <= 3'h1 << k;
			bus(0, 3'h0, 8'h00);
			TK <= 3'h0;
			bus(0, 3'h0, 8'h00);
			bus(2, 3'h7, k == 3 ? 8'hB0 : 8'h90);
			bus(2, 3'h1, k == 3 ? 8'hFF : 8'h00);
			bus(1, 3'h7, 8'h00);
		end
		bus(0, 3'h0, 8'h00);
		$display("source done");
		chk(8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule
